// ===== cdc_clk_if.sv
// rate settings out to the clock generator and its ticks back
`timescale 1ns/10ps
interface cdc_clk_if;
	logic [1:0] mclkDiv; // master clock divider code
	logic [1:0] sclkDiv; // serial clock divider code
	logic [1:0] sampleSel; // sample period code
	logic sclkTick; // one sys_clk pulse at each serial clock rise
	logic sampleTick; // one pulse, coincides with a sclkTick
	logic sclkLevel; // serial clock level, from a flop
	modport gen (input mclkDiv, input sclkDiv, input sampleSel,
		output sclkTick, output sampleTick, output sclkLevel);
	modport port (output mclkDiv, output sclkDiv, output sampleSel,
		input sclkTick, input sampleTick, input sclkLevel);
endinterface

// ===== cdc_clkgen.sv
// serial clock and sample event generator
`timescale 1ns/10ps
`include "cdc_defs.svh"
module cdc_clkgen (
	// system
	input wire logic sys_clk,
	input wire logic reset_n,
	// rates and ticks
	cdc_clk_if.gen clk
);
	import cdc_pkg::*;

	logic [3:0] divCnt_q, divCnt_d; // sys cycles within a half period
	logic level_q, level_d; // serial clock level
	logic [10:0] smpCnt_q, smpCnt_d; // serial clocks within a sample
	logic [1:0] dmDiv; // master divide ratio, code 0 acts as 1
	logic [2:0] sHalf; // half of the serial divide ratio
	logic [3:0] halfLen; // sys cycles per half period
	logic [10:0] smpLen; // serial clocks per sample period
	logic rise; // level about to go high

	// ratio table: divider 1 with code 0 gives DIVIDED_MASTER_CLOCK/8
	always_comb begin
		dmDiv = (clk.mclkDiv == 2'd0) ? 2'd1 : clk.mclkDiv;
		case (clk.sclkDiv)
			2'd0: sHalf = 3'd4;
			2'd1: sHalf = 3'd2;
			default: sHalf = 3'd1; // codes 2 and 3 both give /2
		endcase
		// widen both factors first: divide 3 times half 4 needs all four bits
		halfLen = 4'(dmDiv) * 4'(sHalf);
		smpLen = `CDC_SAMPLE_BASE << clk.sampleSel;
	end

	// half-period counter and sample counter
	always_comb begin
		divCnt_d = divCnt_q + 4'd1;
		level_d = level_q;
		smpCnt_d = smpCnt_q;
		rise = 1'b0;
		if (divCnt_q >= halfLen - 4'd1) begin
			divCnt_d = 4'd0;
			level_d = ~level_q;
			rise = ~level_q;
		end
		if (rise) begin
			// a period change applies at once, to the period in progress
			smpCnt_d = (smpCnt_q >= smpLen - 11'd1) ? 11'd0 : smpCnt_q + 11'd1;
		end
	end

	// registers only
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_q <= 4'd0;
			level_q <= 1'b0;
			smpCnt_q <= 11'd0;
		end else begin
			divCnt_q <= divCnt_d;
			level_q <= level_d;
			smpCnt_q <= smpCnt_d;
		end
	end

	assign clk.sclkLevel = level_q;
	assign clk.sclkTick = rise;
	assign clk.sampleTick = rise && (smpCnt_q == 11'd0);
endmodule

// ===== cdc_defs.svh
// constants of the cascadable codec serial port: offsets, fields, resets, timing
//
// Summary of operation
// - loop-back: each output word draws one input word
// - program mode output words carry no conversion data
// - third register 0x01 powers up analog section
// - data mode: valid ADC out, inputs are DAC
// - first register 0x03 selects mixed mode
// - second register sets serial clock, sample rate
// - fourth register sets encoder channel gain
// - mixed mode DAC word loads DAC register
// - every codec raises output sync on sample (here only when the transmitter is idle; a sample during a word is dropped)
// - nonzero address: decrement and forward word
// - words not for us pass on unchanged
// - zero address word updates own register
// - first register holds device count and mode
// - data mode: count syncs, load DAC on match
// - before count matches, forward current word onward
// - after DAC load, sync counter returns to zero
// - mixed mode: word MSB picks DAC or control
// - mixed mode: only DAC words advance counter
// - addressed read returns selected register contents
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH

// apb byte offsets of the four control registers, the status word and the DAC word
`define CDC_OFS_MODE 8'h00
`define CDC_OFS_RATE 8'h04
`define CDC_OFS_POWER 8'h08
`define CDC_OFS_GAIN 8'h0c
`define CDC_OFS_STATUS 8'h10
`define CDC_OFS_DAC 8'h14

// reset values of the control registers
`define CDC_MODE_RST 8'h00
`define CDC_RATE_RST 8'h00
`define CDC_POWER_RST 8'h00
`define CDC_GAIN_RST 8'h00

// mode_control_reg fields
`define CDC_MODE_PGM 0
`define CDC_MODE_MIX 1
`define CDC_MODE_CNT_HI 6
`define CDC_MODE_CNT_LO 4
`define CDC_MODE_CEE 7

// clock_rate_reg fields
`define CDC_RATE_MDIV_HI 1
`define CDC_RATE_MDIV_LO 0
`define CDC_RATE_SDIV_HI 3
`define CDC_RATE_SDIV_LO 2
`define CDC_RATE_SMP_HI 5
`define CDC_RATE_SMP_LO 4

// power and gain fields
`define CDC_POWER_UP 0
`define CDC_GAIN_HI 2
`define CDC_GAIN_LO 0

// serial word fields
`define CDC_W_CTRL 15
`define CDC_W_READ 14
`define CDC_W_ADDR_HI 13
`define CDC_W_ADDR_LO 11
`define CDC_W_SEL_HI 10
`define CDC_W_SEL_LO 8
`define CDC_W_DATA_HI 7

// timing: serial clocks per sample period at the fastest rate code 0, and bits per serial word
`define CDC_SAMPLE_BASE 11'd256
`define CDC_WORD_BITS 5'd16

`endif

// ===== cdc_host_model.sv
// host serial port model that feeds and drains the codec link
`timescale 1ns/10ps
module cdc_host_model (
	// link from the codec
	input wire logic serialClock,
	input wire logic outFrameSync,
	input wire logic serialOut,
	// link to the codec
	output logic inFrameSync,
	output logic serialIn,
	// bench side
	input wire logic sendReq,
	input wire cdc_pkg::cdcWord_t sendWord,
	output logic sendBusy,
	output cdc_pkg::cdcWord_t rxWord,
	output logic [7:0] rxCnt
);
	import cdc_pkg::*;
	cdcWord_t txSh; // word being shifted out
	cdcWord_t rxSh; // word being gathered
	int txLeft = 0; // bits still to send
	int rxLeft = 0; // bits still to gather
	initial begin
		inFrameSync = 1'b0;
		serialIn = 1'b0;
		sendBusy = 1'b0;
		rxWord = 16'h0000;
		rxCnt = 8'h00;
	end
	// drive on the falling edge so the codec samples a settled line
	always @(negedge serialClock) begin
		if (txLeft > 0) begin
			inFrameSync <= 1'b0;
			serialIn <= txSh[15];
			txSh <= txSh << 1;
			txLeft <= txLeft - 1;
		end else if (sendBusy) begin
			sendBusy <= 1'b0;
			serialIn <= ~serialIn; // a released line never keeps the last bit
		end else if (sendReq) begin
			// one word per bench request, no more
			sendBusy <= 1'b1;
			inFrameSync <= 1'b1;
			txSh <= sendWord;
			txLeft <= 16;
		end else begin
			serialIn <= ~serialIn; // idle line toggles
		end
	end
	// gather at mid-bit, away from the codec's update edge
	always @(negedge serialClock) begin
		if (rxLeft > 0) begin
			rxSh <= {rxSh[14:0], serialOut};
			rxLeft <= rxLeft - 1;
			if (rxLeft == 1) begin
				rxWord <= {rxSh[14:0], serialOut};
				rxCnt <= rxCnt + 8'h01;
			end
		end else if (outFrameSync) begin
			rxLeft <= 16;
		end
	end
endmodule

// ===== cdc_pkg.sv
// types shared by the codec serial port modules
package cdc_pkg;
	// one serial word
	typedef logic [15:0] cdcWord_t;
	// transmit sequencer, one-hot
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SYNC = 3'b010,
		TX_SHIFT = 3'b100
	} cdcTxState_t;
	// receive sequencer, one-hot
	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_SHIFT = 2'b10
	} cdcRxState_t;
endpackage

// ===== cdc_serial_port.sv
// serial port control of the cascadable codec with apb register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "cdc_defs.svh"
module cdc_serial_port (
	// system
	input wire logic sys_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	output logic serialClock,
	output logic outFrameSync,
	output logic serialOut,
	input wire logic inFrameSync,
	input wire logic serialIn,
	// converter side
	input wire cdc_pkg::cdcWord_t adcData,
	output logic adcSampleStrobe,
	output cdc_pkg::cdcWord_t dacData,
	output logic dacLoad,
	output logic analogPowerUp,
	output logic [2:0] adcGain
);
	import cdc_pkg::*;

	cdc_clk_if clk ();

	// control registers: 0 mode, 1 rate, 2 power, 3 gain
	logic [7:0] regs_q [4];
	logic [7:0] regs_d [4];
	logic [31:0] prdata_q, prdata_d; // read data captured in setup
	// receive side
	cdcRxState_t rxState_q, rxState_d;
	cdcWord_t rxShift_q, rxShift_d;
	logic [4:0] rxCnt_q, rxCnt_d;
	logic rxDone; // a full word has arrived this cycle
	// transmit side
	cdcTxState_t txState_q, txState_d;
	cdcWord_t txShift_q, txShift_d;
	logic [4:0] txCnt_q, txCnt_d;
	logic ofs_q, ofs_d;
	logic sout_q, sout_d;
	logic pend_q, pend_d; // one forwarded word waiting for a slot
	cdcWord_t pendWord_q, pendWord_d;
	// word routing
	logic [3:0] fsCnt_q, fsCnt_d; // frame sync counter for DAC routing
	cdcWord_t dac_q, dac_d;
	logic dacLoad_q, dacLoad_d;
	logic fwdReq; // word to go downstream
	cdcWord_t fwdWord;
	logic ctrlWrite; // addressed control write
	logic [2:0] ctrlSel;
	logic [7:0] ctrlData;
	// decoded fields
	logic pgmData, mixed, echoEn;
	logic [3:0] devCount;
	logic isCtrl, isDac;
	logic [2:0] wAddr, wSel;
	logic [7:0] selVal;
	logic apbWr, apbRd;

	assign pgmData = regs_q[0][`CDC_MODE_PGM];
	assign mixed = regs_q[0][`CDC_MODE_MIX];
	assign echoEn = regs_q[0][`CDC_MODE_CEE];
	// a zero count field stands for a full cascade of eight
	assign devCount = (regs_q[0][`CDC_MODE_CNT_HI:`CDC_MODE_CNT_LO] == 3'd0) ? 4'd8 :
		{1'b0, regs_q[0][`CDC_MODE_CNT_HI:`CDC_MODE_CNT_LO]};
	assign wAddr = rxShift_q[`CDC_W_ADDR_HI:`CDC_W_ADDR_LO];
	assign wSel = rxShift_q[`CDC_W_SEL_HI:`CDC_W_SEL_LO];

	// rate settings to the generator, analog controls out
	assign clk.mclkDiv = regs_q[1][`CDC_RATE_MDIV_HI:`CDC_RATE_MDIV_LO];
	assign clk.sclkDiv = regs_q[1][`CDC_RATE_SDIV_HI:`CDC_RATE_SDIV_LO];
	assign clk.sampleSel = regs_q[1][`CDC_RATE_SMP_HI:`CDC_RATE_SMP_LO];
	assign analogPowerUp = regs_q[2][`CDC_POWER_UP];
	assign adcGain = regs_q[3][`CDC_GAIN_HI:`CDC_GAIN_LO];
	assign serialClock = clk.sclkLevel;
	assign adcSampleStrobe = clk.sampleTick;

	cdc_clkgen u_clkgen (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk(clk)
	);

	// apb: zero wait states, read data registered during setup
	assign apbWr = psel && penable && pwrite;
	assign apbRd = psel && !penable && !pwrite;
	assign pready = psel && penable;
	assign pslverr = psel && penable && (paddr > `CDC_OFS_DAC || paddr[1:0] != 2'b00);
	assign prdata = prdata_q;

	always_comb begin
		prdata_d = prdata_q;
		if (apbRd) begin
			case (paddr)
				`CDC_OFS_MODE: prdata_d = {24'h000000, regs_q[0]};
				`CDC_OFS_RATE: prdata_d = {24'h000000, regs_q[1]};
				`CDC_OFS_POWER: prdata_d = {24'h000000, regs_q[2]};
				`CDC_OFS_GAIN: prdata_d = {24'h000000, regs_q[3]};
				// status: counter, busy flags, pending word
				`CDC_OFS_STATUS: prdata_d = {20'h00000, fsCnt_q, 2'b00, pend_q,
					txState_q != TX_IDLE, rxState_q != RX_IDLE, 1'b0, mixed, pgmData};
				`CDC_OFS_DAC: prdata_d = {16'h0000, dac_q};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	// selected register value for an addressed read
	always_comb begin
		selVal = 8'h00;
		if (wSel < 3'd4) begin
			selVal = regs_q[wSel[1:0]];
		end
	end

	// word routing: control, DAC or pass-through
	always_comb begin
		fwdReq = 1'b0;
		fwdWord = rxShift_q;
		ctrlWrite = 1'b0;
		ctrlSel = wSel;
		ctrlData = rxShift_q[`CDC_W_DATA_HI:0];
		fsCnt_d = fsCnt_q;
		dac_d = dac_q;
		dacLoad_d = 1'b0;
		// program mode has no DAC words and, like mixed, takes a word as control only with the MSB set
		isCtrl = rxShift_q[`CDC_W_CTRL] && (!pgmData || mixed);
		isDac = pgmData && (!mixed || !rxShift_q[`CDC_W_CTRL]);
		if (rxDone) begin
			if (isDac) begin
				// only DAC words move the counter
				if (fsCnt_q + 4'd1 == devCount) begin
					dac_d = rxShift_q;
					dacLoad_d = 1'b1;
					fsCnt_d = 4'd0;
				end else begin
					fsCnt_d = fsCnt_q + 4'd1;
					fwdReq = 1'b1;
				end
			end else if (isCtrl && wAddr != 3'd0) begin
				fwdWord[`CDC_W_ADDR_HI:`CDC_W_ADDR_LO] = wAddr - 3'd1;
				fwdReq = 1'b1;
			end else if (isCtrl && rxShift_q[`CDC_W_READ]) begin
				fwdWord = {rxShift_q[15:8], selVal};
				fwdReq = 1'b1;
			end else if (isCtrl) begin
				ctrlWrite = (wSel < 3'd4);
				fwdReq = echoEn;
			end else begin
				fwdReq = 1'b1;
			end
		end
	end

	// register file: a serial write lands after an apb write and wins
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (apbWr && paddr <= `CDC_OFS_GAIN && paddr[1:0] == 2'b00) begin
			regs_d[paddr[3:2]] = pwdata[7:0];
		end
		if (ctrlWrite) begin
			regs_d[ctrlSel[1:0]] = ctrlData;
		end
	end

	// one flop group per control register
	for (genvar g = 0; g < 4; g++) begin : g_reg
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				regs_q[g] <= (g == 0) ? `CDC_MODE_RST : (g == 1) ? `CDC_RATE_RST :
					(g == 2) ? `CDC_POWER_RST : `CDC_GAIN_RST;
			end else begin
				regs_q[g] <= regs_d[g];
			end
		end
	end

	// receive: sync seen on one serial clock, 16 bits on the next 16
	always_comb begin
		rxState_d = rxState_q;
		rxShift_d = rxShift_q;
		rxCnt_d = rxCnt_q;
		rxDone = 1'b0;
		case (rxState_q)
			RX_IDLE: begin
				if (clk.sclkTick && inFrameSync) begin
					rxState_d = RX_SHIFT;
					rxCnt_d = 5'd0;
				end
			end
			RX_SHIFT: begin
				if (clk.sclkTick) begin
					rxShift_d = {rxShift_q[14:0], serialIn};
					rxCnt_d = rxCnt_q + 5'd1;
					if (rxCnt_q == `CDC_WORD_BITS - 5'd1) begin
						rxState_d = RX_IDLE;
					end
				end
			end
			default: rxState_d = RX_IDLE;
		endcase
		// the word is complete one cycle after the last bit is taken
		if (rxState_q == RX_IDLE && rxCnt_q == `CDC_WORD_BITS) begin
			rxDone = 1'b1;
			rxCnt_d = 5'd0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxState_q <= RX_IDLE;
			rxShift_q <= 16'h0000;
			rxCnt_q <= 5'd0;
		end else begin
			rxState_q <= rxState_d;
			rxShift_q <= rxShift_d;
			rxCnt_q <= rxCnt_d;
		end
	end

	// transmit: sample words take priority, forwarded words wait one deep
	always_comb begin
		txState_d = txState_q;
		txShift_d = txShift_q;
		txCnt_d = txCnt_q;
		ofs_d = ofs_q;
		sout_d = sout_q;
		pend_d = pend_q;
		pendWord_d = pendWord_q;
		if (fwdReq) begin
			// a second word before the first leaves overwrites it
			pend_d = 1'b1;
			pendWord_d = fwdWord;
		end
		if (clk.sclkTick) begin
			case (txState_q)
				TX_IDLE: begin
					if (clk.sampleTick) begin
						// program mode words hold no conversion data
						txShift_d = pgmData ? adcData : 16'h0000;
						ofs_d = 1'b1;
						txState_d = TX_SYNC;
					end else if (pend_q) begin
						txShift_d = pendWord_q;
						pend_d = fwdReq;
						ofs_d = 1'b1;
						txState_d = TX_SYNC;
					end
				end
				TX_SYNC: begin
					ofs_d = 1'b0;
					sout_d = txShift_q[15];
					txShift_d = {txShift_q[14:0], 1'b0};
					txCnt_d = 5'd1;
					txState_d = TX_SHIFT;
				end
				TX_SHIFT: begin
					if (txCnt_q == `CDC_WORD_BITS) begin
						sout_d = 1'b0;
						txState_d = TX_IDLE;
					end else begin
						sout_d = txShift_q[15];
						txShift_d = {txShift_q[14:0], 1'b0};
						txCnt_d = txCnt_q + 5'd1;
					end
				end
				default: txState_d = TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			txState_q <= TX_IDLE;
			txShift_q <= 16'h0000;
			txCnt_q <= 5'd0;
			ofs_q <= 1'b0;
			sout_q <= 1'b0;
			pend_q <= 1'b0;
			pendWord_q <= 16'h0000;
		end else begin
			txState_q <= txState_d;
			txShift_q <= txShift_d;
			txCnt_q <= txCnt_d;
			ofs_q <= ofs_d;
			sout_q <= sout_d;
			pend_q <= pend_d;
			pendWord_q <= pendWord_d;
		end
	end

	// routing state and apb read data
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fsCnt_q <= 4'd0;
			dac_q <= 16'h0000;
			dacLoad_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			fsCnt_q <= fsCnt_d;
			dac_q <= dac_d;
			dacLoad_q <= dacLoad_d;
			prdata_q <= prdata_d;
		end
	end

	assign outFrameSync = ofs_q;
	assign serialOut = sout_q;
	assign dacData = dac_q;
	assign dacLoad = dacLoad_q;
endmodule

// ===== cdc_serial_port_checker.sv
// concurrent checks on the pins of the codec serial port
`timescale 1ns/10ps
module cdc_serial_port_checker (
	// system
	input wire logic sys_clk,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// link and converter side
	input wire logic serialClock,
	input wire logic outFrameSync,
	input wire logic serialOut,
	input wire cdc_pkg::cdcWord_t dacData,
	input wire logic dacLoad,
	input wire logic analogPowerUp,
	input wire logic [2:0] adcGain
);
	import cdc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// access phase of a write to one offset
	sequence sWrite(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	// off the map or off a word boundary
	logic badAddr;
	assign badAddr = (paddr > 8'h14) || (paddr[1:0] != 2'h0);
	// zero wait states, so the answer always lands in the access cycle
	a_ready_access: assert property (pready == (psel && penable))
		else $error("pready outside access");
	a_error_refuse: assert property (pslverr == (psel && penable && badAddr))
		else $error("pslverr wrong");
	a_power_write: assert property (sWrite(8'h08) |=> analogPowerUp == $past(pwdata[0]))
		else $error("power bit not taken");
	a_gain_write: assert property (sWrite(8'h0c) |=> adcGain == $past(pwdata[2:0]))
		else $error("gain not taken");
	a_dac_cause: assert property ($changed(dacData) |-> dacLoad)
		else $error("dac word moved without load");
	a_load_pulse: assert property (dacLoad |=> (!dacLoad) [*8])
		else $error("dac load too long");
	// outputs move only in the high phase of the serial clock
	a_sync_edge: assert property ($changed(outFrameSync) |-> serialClock)
		else $error("frame sync off clock");
	a_bit_edge: assert property ($changed(serialOut) |-> serialClock)
		else $error("data bit off clock");
endmodule
bind cdc_serial_port cdc_serial_port_checker chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .serialClock(serialClock),
	.outFrameSync(outFrameSync), .serialOut(serialOut), .dacData(dacData),
	.dacLoad(dacLoad), .analogPowerUp(analogPowerUp), .adcGain(adcGain));

// ===== cdc_serial_port_tb.sv
// self-checking bench for the codec serial port with a host on the link
`timescale 1ns/10ps
module cdc_serial_port_tb;
	import cdc_pkg::*;
	// {write, refused}, offset, write data, expected read data
	typedef struct {logic [1:0] f; logic [7:0] a; logic [31:0] d; logic [31:0] x;} cdcApbRow_t;
	// {apb mode write, word back, dac load}, mode, word sent, expected word
	typedef struct {logic [2:0] f; logic [7:0] m; cdcWord_t t; cdcWord_t x;} cdcSerRow_t;
	localparam cdcWord_t ADC = 16'ha5c3; // base converter word, moved on by one per row
	cdcWord_t adc = ADC; // word on adcData; changing it exposes a stale sample
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, serialClock, outFrameSync, serialOut, inFrameSync, serialIn;
	cdcWord_t dacData, sendWord = 16'h0000, rxWord, w;
	logic dacLoad, analogPowerUp, sendReq = 1'b0, sendBusy, e, adcSampleStrobe;
	logic [2:0] adcGain;
	logic [7:0] rxCnt;
	logic [31:0] r, l0, s0, smpCnt = 32'h0, loadCnt = 32'h0, badCount = 32'h0, numChecks = 32'h0;
	int cyc = 0, c1;
	cdcApbRow_t ar [10] = '{'{2'h0, 8'h00, 32'h0, 32'h0}, '{2'h0, 8'h04, 32'h0, 32'h0},
		'{2'h2, 8'h04, 32'h0, 32'h0}, '{2'h2, 8'h08, 32'h1, 32'h0},
		'{2'h0, 8'h08, 32'h0, 32'h1}, '{2'h2, 8'h0c, 32'h5, 32'h0},
		'{2'h0, 8'h0c, 32'h0, 32'h5}, '{2'h3, 8'h18, 32'hff, 32'h0},
		'{2'h1, 8'h1a, 32'h0, 32'h0}, '{2'h0, 8'h14, 32'h0, 32'h0}};
	cdcSerRow_t sr [17] = '{
		'{3'h2, 8'h00, 16'h9a55, 16'h9255},
		'{3'h2, 8'h00, 16'h1234, 16'h1234},
		'{3'h0, 8'h00, 16'h8200, 16'h0000},
		'{3'h2, 8'h00, 16'hc200, 16'hc200},
		'{3'h0, 8'h00, 16'h8306, 16'h0000},
		'{3'h2, 8'h00, 16'hc300, 16'hc306},
		'{3'h0, 8'h00, 16'h8011, 16'h0000},
		'{3'h1, 8'h00, 16'h4321, 16'h4321},
		'{3'h6, 8'h21, 16'h1111, 16'h1111},
		'{3'h1, 8'h00, 16'ha222, 16'ha222},
		'{3'h2, 8'h00, 16'h3333, 16'h3333},
		'{3'h1, 8'h00, 16'h4444, 16'h4444},
		'{3'h6, 8'h23, 16'h9a55, 16'h9255},
		'{3'h2, 8'h00, 16'h5555, 16'h5555},
		'{3'h1, 8'h00, 16'h6666, 16'h6666},
		'{3'h0, 8'h00, 16'h8003, 16'h0000},
		'{3'h2, 8'h00, 16'hc000, 16'hc003}};
	cdc_serial_port uut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .serialClock(serialClock),
		.outFrameSync(outFrameSync), .serialOut(serialOut), .inFrameSync(inFrameSync),
		.serialIn(serialIn), .adcData(adc), .adcSampleStrobe(adcSampleStrobe), .dacData(dacData),
		.dacLoad(dacLoad), .analogPowerUp(analogPowerUp), .adcGain(adcGain));
	cdc_host_model host (.serialClock(serialClock), .outFrameSync(outFrameSync),
		.serialOut(serialOut), .inFrameSync(inFrameSync), .serialIn(serialIn),
		.sendReq(sendReq), .sendWord(sendWord), .sendBusy(sendBusy),
		.rxWord(rxWord), .rxCnt(rxCnt));
	always #2 sys_clk = ~sys_clk;
	// dac loads and sample strobes are counted so a row can check it got one sample and the zero or one load it expects
	always @(posedge sys_clk) begin
		if (dacLoad === 1'b1) loadCnt <= loadCnt + 32'h1;
		if (adcSampleStrobe === 1'b1) smpCnt <= smpCnt + 32'h1;
		cyc++;
		if (cyc == 90000) begin
			badCount++;
			endSim();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// next word the host gathers; the watchdog bounds the wait
	task getRx(output cdcWord_t wd);
		logic [7:0] c0;
		c0 = rxCnt;
		while (rxCnt === c0) @(posedge sys_clk);
		wd = rxWord;
	endtask
	task send(input cdcWord_t wd);
		@(posedge sys_clk);
		sendWord <= wd;
		sendReq <= 1'b1;
		wait (sendBusy === 1'b1);
		@(posedge sys_clk);
		sendReq <= 1'b0;
		wait (sendBusy === 1'b0);
	endtask
	task endSim;
		if (badCount == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			apb(ar[i].f[1], ar[i].a, ar[i].d, r, e);
			chk({31'h0, e}, {31'h0, ar[i].f[0]});
			if (!ar[i].f[1]) chk(r, ar[i].x);
		end
		chk({31'h0, analogPowerUp}, 32'h1);
		// each row starts right after a sample word so nothing collides with it
		for (int i = 0; i <= 17; i++) begin
			getRx(w);
			if (i > 0) begin
				chk(smpCnt - s0, 32'h1);
				chk(loadCnt - l0, {31'h0, sr[i-1].f[0]});
				if (sr[i-1].f[0]) chk({16'h0, dacData}, {16'h0, sr[i-1].x});
			end
			s0 = smpCnt;
			if (i < 17) begin
				chk({16'h0, w}, {16'h0, (i < 7) ? 16'h0000 : ADC + 16'(i)});
				adc <= ADC + 16'(i + 1);
				l0 = loadCnt;
				if (sr[i].f[2]) apb(1'b1, 8'h00, {24'h0, sr[i].m}, r, e);
				send(sr[i].t);
				if (sr[i].f[1]) begin
					getRx(w);
					chk({16'h0, w}, {16'h0, sr[i].x});
				end
			end
		end
		chk({31'h0, analogPowerUp}, 32'h0);
		chk({29'h0, adcGain}, 32'h6);
		// echo on in program mode: an own control write comes back unchanged
		apb(1'b1, 8'h00, 32'h80, r, e);
		send(16'h8305);
		getRx(w);
		chk({16'h0, w}, 32'h8305);
		chk({29'h0, adcGain}, 32'h5);
		// master divide 3, serial code 0: eight times three system clocks per serial clock
		apb(1'b1, 8'h04, 32'h03, r, e);
		repeat (2) @(posedge serialClock);
		c1 = cyc;
		@(posedge serialClock);
		chk(32'(cyc - c1), 32'd24);
		// second reset in mid-run returns the pins to their reset levels
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({29'h0, adcGain}, 32'h0);
		chk({16'h0, dacData}, 32'h0);
		reset_n <= 1'b1;
		// two edges after release the link pins still sit at their reset levels
		repeat (2) @(posedge sys_clk);
		chk({29'h0, serialClock, outFrameSync, serialOut}, 32'h0);
		endSim();
	end
endmodule
